// file: hdl/ssw_pkg.sv
// Purpose: Shared constants and types of the coded safety switch output logic
// Assumes: 125 MHz system clock
// Notes:   Diagnostic chain timing and command codes are block-local choices

package ssw_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int BIT_TIME_NS = 10000;
  localparam int BIT_CYC = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HALF_BIT_CYC = BIT_CYC / 2;
  localparam int DETECT_TIME_US = 1000;
  localparam int DETECT_CYC = (DETECT_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 17;

  // ----------------------------------------------------------------
  // Diagnostic chain framing
  // ----------------------------------------------------------------
  localparam int MAX_SENSORS = 16;
  localparam int ADDR_W = 4;
  localparam int DATA_BITS = 8;
  localparam int REPLY_BITS = 20;
  localparam int BITN_W = 5;
  localparam logic [3:0] CMD_SERIAL = 4'h1;
  localparam logic [3:0] CMD_CONFIG = 4'h2;
  localparam logic [3:0] CMD_NAME = 4'h3;
  localparam logic [3:0] CMD_STATUS = 4'h4;

  // ----------------------------------------------------------------
  // Synchroniser lanes
  // ----------------------------------------------------------------
  localparam int SYNC_W = 5;
  localparam int SY_CH1 = 0;
  localparam int SY_CH2 = 1;
  localparam int SY_ACT = 2;
  localparam int SY_DIAG = 3;
  localparam int SY_RDY = 4;

  // ----------------------------------------------------------------
  // Indicator codes
  // ----------------------------------------------------------------
  localparam logic [1:0] LED_OFF = 2'h0;
  localparam logic [1:0] LED_ON = 2'h1;
  localparam logic [1:0] LED_FAST_FLASH = 2'h2;
  localparam logic [1:0] LED_FLASH = 2'h3;
  localparam logic [1:0] DEV_GREEN = 2'h0;
  localparam logic [1:0] DEV_RED_FLASH = 2'h1;
  localparam logic [1:0] DEV_RED = 2'h2;

  typedef enum logic [1:0] {
    CHK_OK = 2'b00,
    CHK_UNEQUAL = 2'b01,
    CHK_LOCK = 2'b10
  } ssw_chk_e;

  typedef enum logic [1:0] {
    DG_DETECT = 2'b00,
    DG_IDLE = 2'b01,
    DG_RX = 2'b10,
    DG_TX = 2'b11
  } ssw_diag_e;

endpackage

// file: hdl/ssw_safety_switch.sv
// Purpose: Output interlock, feasibility check and diagnostic chain of a coded safety switch
// Assumes: All pin inputs are asynchronous to clock
// Notes:   Safety path never depends on the diagnostic chain state
//
// Overview of operation
// - Ready with actuator present: each safety output follows its own chain input.
// - No actuator detected: both safety outputs low regardless of inputs.
// - Without diagnostic chain, signal output shows actuator presence only.
// - One input falls while other high: show unequal status on indicators.
// - Same input rises while other high: feasibility error and partial lock.
// - Normal switching resumes only after both inputs were low together.
// - With fieldbus module present, diagnostic input is enabled and read.
// - Without fieldbus module, diagnostic input is only watched for module detection.
// - In chain mode the signal output carries reply data to the module.
// - Chain holds up to sixteen series sensors, each one addressed subscriber.
// - Diagnostic link re-established automatically after every power-up.
// - Serial number readable over the diagnostic chain.
// - Configuration, including remaining teach-in count, returned on request.
// - Actuator short name reported when the module polls it.
// - Status reply tells switched state and where the chain is open.
// - Diagnostic chain optional; it never alters safety input/output behaviour.
// - After actuator removal outputs stay off until actuator detected again.

`timescale 1ns/1ps

module ssw_safety_switch
  import ssw_pkg::*;
#(
  parameter int DETECT_CYCLES = DETECT_CYC,
  parameter int BIT_CYCLES = BIT_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Safety chain inputs
  input wire logic first_chain_input,
  input wire logic second_chain_input,
  // Sensor state
  input wire logic actuator_present,
  input wire logic device_ready,
  // Diagnostic chain
  input wire logic diag_receive_input,
  input wire logic [ADDR_W-1:0] chain_position,
  // Device data reported over the chain
  input wire logic [15:0] serial_number,
  input wire logic [7:0] teach_remaining,
  input wire logic [15:0] actuator_name,
  // Safety and signal outputs
  output logic safety_out_first,
  output logic safety_out_second,
  output logic signal_diag_output,
  // Indicators and status
  output logic [1:0] input_led,
  output logic [1:0] device_led,
  output logic feasibility_error,
  output logic diag_mode
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] pin_in;
  logic [SYNC_W-1:0] sync1_ff;
  logic [SYNC_W-1:0] sync2_ff;
  logic [SYNC_W-1:0] sync3_ff;
  logic [SYNC_W-1:0] stable_ff;
  logic [SYNC_W-1:0] nxt_stable;
  logic [SYNC_W-1:0] agree;

  assign pin_in = {device_ready, diag_receive_input, actuator_present,
                   second_chain_input, first_chain_input};
  // A change counts only once the second and third stages agree
  assign agree = ~(sync2_ff ^ sync3_ff);
  assign nxt_stable = (agree & sync3_ff) | (~agree & stable_ff);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
      stable_ff <= '0;
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      stable_ff <= nxt_stable;
    end
  end

  // ----------------------------------------------------------------
  // Feasibility check of the two chain inputs
  // ----------------------------------------------------------------
  logic in1;
  logic in2;
  logic act;
  logic rdy;
  logic prev1_ff;
  logic prev2_ff;
  logic fall1;
  logic fall2;
  logic rise1;
  logic rise2;
  logic both_low;
  logic hold1;
  logic hold2;
  logic rise_side;
  logic other_high;
  ssw_chk_e chk_ff;
  ssw_chk_e nxt_chk;
  logic side_ff;
  logic nxt_side;

  assign in1 = stable_ff[SY_CH1];
  assign in2 = stable_ff[SY_CH2];
  assign act = stable_ff[SY_ACT];
  assign rdy = stable_ff[SY_RDY];
  assign fall1 = prev1_ff & ~in1;
  assign fall2 = prev2_ff & ~in2;
  assign rise1 = ~prev1_ff & in1;
  assign rise2 = ~prev2_ff & in2;
  assign both_low = ~in1 & ~in2;
  // The other channel must be high before and after, not merely rising now
  assign hold1 = prev1_ff & in1;
  assign hold2 = prev2_ff & in2;
  assign rise_side = side_ff ? rise2 : rise1;
  assign other_high = side_ff ? hold1 : hold2;

  always_comb begin
    nxt_chk = chk_ff;
    nxt_side = side_ff;
    unique case (chk_ff)
      CHK_OK: begin
        if (fall1 & hold2) begin
          nxt_chk = CHK_UNEQUAL;
          nxt_side = 1'b0;
        end else if (fall2 & hold1) begin
          nxt_chk = CHK_UNEQUAL;
          nxt_side = 1'b1;
        end
      end
      CHK_UNEQUAL: begin
        if (both_low) begin
          nxt_chk = CHK_OK;
        end else if (rise_side & other_high) begin
          nxt_chk = CHK_LOCK;
        end
      end
      CHK_LOCK: begin
        // Only a common low of both channels releases the lock
        if (both_low) begin
          nxt_chk = CHK_OK;
        end
      end
      default: begin
        nxt_chk = CHK_OK;
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      chk_ff <= CHK_OK;
      side_ff <= 1'b0;
      prev1_ff <= 1'b0;
      prev2_ff <= 1'b0;
    end else begin
      chk_ff <= nxt_chk;
      side_ff <= nxt_side;
      prev1_ff <= in1;
      prev2_ff <= in2;
    end
  end

  // ----------------------------------------------------------------
  // Safety outputs and indicators
  // ----------------------------------------------------------------
  logic enable;
  logic lock1;
  logic lock2;
  logic nxt_out1;
  logic nxt_out2;
  logic [1:0] nxt_input_led;
  logic [1:0] nxt_device_led;

  // Only the offending channel is held off, from the unequal state on;
  // the next state is used so a returning input never pulses its output
  assign enable = rdy & act;
  assign lock1 = (nxt_chk != CHK_OK) & ~nxt_side;
  assign lock2 = (nxt_chk != CHK_OK) & nxt_side;
  assign nxt_out1 = enable & in1 & ~lock1;
  assign nxt_out2 = enable & in2 & ~lock2;
  assign nxt_input_led = (chk_ff == CHK_LOCK) ? LED_FLASH :
                         (chk_ff == CHK_UNEQUAL) ? LED_FAST_FLASH :
                         (in1 | in2) ? LED_ON : LED_OFF;
  assign nxt_device_led = ~rdy ? DEV_RED :
                          (chk_ff != CHK_OK) ? DEV_RED_FLASH : DEV_GREEN;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      safety_out_first <= 1'b0;
      safety_out_second <= 1'b0;
      input_led <= LED_OFF;
      device_led <= DEV_RED;
      feasibility_error <= 1'b0;
    end else begin
      safety_out_first <= nxt_out1;
      safety_out_second <= nxt_out2;
      input_led <= nxt_input_led;
      device_led <= nxt_device_led;
      feasibility_error <= (chk_ff == CHK_LOCK);
    end
  end

  // ----------------------------------------------------------------
  // Diagnostic chain: reply data
  // ----------------------------------------------------------------
  logic diag;
  logic [DATA_BITS-1:0] rx_sh_ff;
  logic [DATA_BITS-1:0] nxt_rx_sh;
  logic [ADDR_W-1:0] addr_ff;
  logic [ADDR_W-1:0] nxt_addr;
  logic [3:0] cmd;
  logic addr_hit;
  logic cmd_known;
  logic [7:0] status_byte;
  logic [15:0] reply_word;
  logic [REPLY_BITS-1:0] reply_frame;

  // Ignored while no fieldbus module has been seen
  assign diag = stable_ff[SY_DIAG] & diag_mode;
  assign cmd = rx_sh_ff[3:0];
  assign addr_hit = (rx_sh_ff[DATA_BITS-1:ADDR_W] == addr_ff);
  assign cmd_known = (cmd == CMD_SERIAL) | (cmd == CMD_CONFIG) |
                     (cmd == CMD_NAME) | (cmd == CMD_STATUS);
  // A low chain input here and high upstream locates an open circuit
  assign status_byte = {rdy, (chk_ff == CHK_LOCK), (chk_ff == CHK_UNEQUAL),
                        safety_out_second, safety_out_first, in2, in1, act};
  assign reply_word = (cmd == CMD_SERIAL) ? serial_number :
                      (cmd == CMD_CONFIG) ? {teach_remaining, 8'h00} :
                      (cmd == CMD_NAME) ? actuator_name :
                      {8'h00, status_byte};
  assign reply_frame = {1'b1, reply_word[15:8], 1'b0,
                        1'b1, reply_word[7:0], 1'b0};

  // ----------------------------------------------------------------
  // Diagnostic chain: link sequencer
  // ----------------------------------------------------------------
  ssw_diag_e dg_ff;
  ssw_diag_e nxt_dg;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic [BITN_W-1:0] bitn_ff;
  logic [BITN_W-1:0] nxt_bitn;
  logic [REPLY_BITS-1:0] tx_sh_ff;
  logic [REPLY_BITS-1:0] nxt_tx_sh;
  logic nxt_mode;
  logic nxt_signal;
  logic cnt_zero;
  localparam int HALF_BIT_CYCLES = BIT_CYCLES / 2;

  assign cnt_zero = (cnt_ff == '0);

  always_comb begin
    nxt_dg = dg_ff;
    nxt_cnt = cnt_ff;
    nxt_bitn = bitn_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_addr = addr_ff;
    nxt_mode = diag_mode;
    unique case (dg_ff)
      DG_DETECT: begin
        // A module holds the line high; a steady high after power-up means present
        if (!stable_ff[SY_DIAG]) begin
          nxt_cnt = '0;
        end else if (cnt_ff == CNT_W'(DETECT_CYCLES - 1)) begin
          nxt_dg = DG_IDLE;
          nxt_mode = 1'b1;
          nxt_addr = chain_position;
          nxt_cnt = '0;
        end else begin
          nxt_cnt = cnt_ff + CNT_W'(1);
        end
      end
      DG_IDLE: begin
        if (!diag) begin
          nxt_dg = DG_RX;
          nxt_cnt = CNT_W'(BIT_CYCLES + HALF_BIT_CYCLES - 1);
          nxt_bitn = '0;
        end
      end
      DG_RX: begin
        if (!cnt_zero) begin
          nxt_cnt = cnt_ff - CNT_W'(1);
        end else if (bitn_ff == BITN_W'(DATA_BITS)) begin
          // Stop bit sample; a framing error or a foreign address gets no reply
          if (diag & addr_hit & cmd_known) begin
            nxt_dg = DG_TX;
            nxt_tx_sh = reply_frame;
            nxt_cnt = CNT_W'(BIT_CYCLES - 1);
            nxt_bitn = '0;
          end else begin
            nxt_dg = DG_IDLE;
          end
        end else begin
          nxt_rx_sh = {diag, rx_sh_ff[DATA_BITS-1:1]};
          nxt_bitn = bitn_ff + BITN_W'(1);
          nxt_cnt = CNT_W'(BIT_CYCLES - 1);
        end
      end
      DG_TX: begin
        if (!cnt_zero) begin
          nxt_cnt = cnt_ff - CNT_W'(1);
        end else if (bitn_ff == BITN_W'(REPLY_BITS - 1)) begin
          nxt_dg = DG_IDLE;
          nxt_tx_sh = '1;
        end else begin
          nxt_tx_sh = {1'b1, tx_sh_ff[REPLY_BITS-1:1]};
          nxt_bitn = bitn_ff + BITN_W'(1);
          nxt_cnt = CNT_W'(BIT_CYCLES - 1);
        end
      end
    endcase
  end

  // Chain mode swaps the presence signal for reply data; idle line stays high
  assign nxt_signal = diag_mode ? ((dg_ff == DG_TX) ? tx_sh_ff[0] : 1'b1)
                                : act;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      dg_ff <= DG_DETECT;
      cnt_ff <= '0;
      bitn_ff <= '0;
      rx_sh_ff <= '0;
      tx_sh_ff <= '1;
      addr_ff <= '0;
      diag_mode <= 1'b0;
      signal_diag_output <= 1'b0;
    end else begin
      dg_ff <= nxt_dg;
      cnt_ff <= nxt_cnt;
      bitn_ff <= nxt_bitn;
      rx_sh_ff <= nxt_rx_sh;
      tx_sh_ff <= nxt_tx_sh;
      addr_ff <= nxt_addr;
      diag_mode <= nxt_mode;
      signal_diag_output <= nxt_signal;
    end
  end

endmodule // ssw_safety_switch

// file: tb/ssw_assertions.sv
// Purpose: Port-level checks of the safety switch
// Assumes: Bound to every switch instance
// Notes:   Windows of 7 or 8 cycles cover the input synchroniser lag
`timescale 1ns/1ps
module ssw_assertions
  import ssw_pkg::*;
#(
  parameter int DETECT_CYCLES = DETECT_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Watched inputs
  input wire logic first_chain_input,
  input wire logic second_chain_input,
  input wire logic actuator_present,
  input wire logic device_ready,
  input wire logic diag_receive_input,
  // Watched outputs
  input wire logic safety_out_first,
  input wire logic safety_out_second,
  input wire logic signal_diag_output,
  input wire logic [1:0] input_led,
  input wire logic [1:0] device_led,
  input wire logic feasibility_error,
  input wire logic diag_mode
);
  logic [CNT_W-1:0] hi_cnt_ff;
  // Raw high run of the line; saturates so it never wraps to zero
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      hi_cnt_ff <= '0;
    end else if (!diag_receive_input) begin
      hi_cnt_ff <= '0;
    end else if (hi_cnt_ff != '1) begin
      hi_cnt_ff <= hi_cnt_ff + 1'b1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_absent_off: assert property (
    !actuator_present [*7] |-> !safety_out_first && !safety_out_second)
    else $error("safety output on without actuator");
  a_follow_first: assert property (
    (device_ready && actuator_present && first_chain_input && !feasibility_error
     && input_led != LED_FAST_FLASH) [*8]
    |-> safety_out_first) else $error("first output not following");
  a_follow_second: assert property (
    (device_ready && actuator_present && second_chain_input && !feasibility_error
     && input_led != LED_FAST_FLASH) [*8]
    |-> safety_out_second) else $error("second output not following");
  a_low_first: assert property (
    !first_chain_input [*7] |-> !safety_out_first)
    else $error("first output high with input low");
  a_signal_presence: assert property (
    (!diag_mode && $stable(actuator_present)) [*7] |-> signal_diag_output == actuator_present)
    else $error("signal output not showing presence");
  a_detect_needs_line: assert property (
    $rose(diag_mode) |-> $past(hi_cnt_ff, 6) >= DETECT_CYCLES - 8)
    else $error("chain mode without steady high line");
  a_mode_sticky: assert property (diag_mode |=> diag_mode)
    else $error("chain mode dropped");
  a_lock_leds: assert property (
    $rose(feasibility_error) |-> ##[0:1] (input_led == LED_FLASH && device_led == DEV_RED_FLASH))
    else $error("lock indication missing");
  c_lock: cover property ($rose(feasibility_error));
  c_unequal: cover property (input_led == LED_FAST_FLASH);
  c_chain: cover property ($rose(diag_mode));
endmodule // ssw_assertions

bind ssw_safety_switch ssw_assertions #(.DETECT_CYCLES(DETECT_CYCLES)) u_chk (
  .clock(clock), .reset(reset), .first_chain_input(first_chain_input),
  .second_chain_input(second_chain_input), .actuator_present(actuator_present),
  .device_ready(device_ready), .diag_receive_input(diag_receive_input),
  .safety_out_first(safety_out_first), .safety_out_second(safety_out_second),
  .signal_diag_output(signal_diag_output), .input_led(input_led), .device_led(device_led),
  .feasibility_error(feasibility_error), .diag_mode(diag_mode));

// file: tb/ssw_fieldbus_model.sv
// Purpose: Fieldbus module on the diagnostic chain
// Assumes: Line pulled low while no module is attached
// Notes:   Drives and samples at the falling edge
`timescale 1ns/1ps
module ssw_fieldbus_model
  import ssw_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYC
) (
  // Clock and device output
  input wire logic clock,
  input wire logic signal_diag_output,
  // Line towards the device
  output logic diag_receive_input
);
  logic attached = 1'b0;
  logic tx_level = 1'b1;
  // Attaching after power-up is all it takes to bring the link up
  assign diag_receive_input = attached ? tx_level : 1'b0;

  task automatic bit_out(input logic b);
    tx_level = b;
    repeat (BIT_CYCLES) @(negedge clock);
  endtask

  // Addressed command byte, then two reply frames, low byte first
  task automatic xfer(input logic [7:0] cmd, output logic [15:0] word, output logic ok);
    logic [19:0] r;
    int n;
    bit_out(1'b0);
    for (int i = 0; i < 8; i++) begin
      bit_out(cmd[i]);
    end
    // Stop bit and idle share one level; the reply may start mid stop bit
    tx_level = 1'b1;
    n = 0;
    while (signal_diag_output !== 1'b0 && n < 3 * BIT_CYCLES) begin
      @(negedge clock);
      n++;
    end
    repeat (BIT_CYCLES / 2) @(negedge clock);
    for (int i = 0; i < 20; i++) begin
      r[i] = signal_diag_output;
      repeat (BIT_CYCLES) @(negedge clock);
    end
    word = {r[18:11], r[8:1]};
    ok = (n < 3 * BIT_CYCLES) && (r[0] === 1'b0) && (r[9] === 1'b1)
      && (r[10] === 1'b0) && (r[19] === 1'b1);
  endtask
endmodule // ssw_fieldbus_model

// file: tb/tb_ssw_safety_switch.sv
// Purpose: Self-checking bench of the safety switch
// Assumes: Detect count shortened to 20 cycles, bit time to 40 cycles
// Notes:   Chain transfers take most of the run
`timescale 1ns/1ps
module tb_ssw_safety_switch
  import ssw_pkg::*;
;
  localparam int DET = 20;
  localparam int BIT = 40;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic first_chain_input = 1'b1;
  logic second_chain_input = 1'b1;
  logic actuator_present = 1'b1;
  logic device_ready = 1'b1;
  logic diag_receive_input;
  logic safety_out_first;
  logic safety_out_second;
  logic signal_diag_output;
  logic [1:0] input_led;
  logic [1:0] device_led;
  logic feasibility_error;
  logic diag_mode;
  int error_cnt = 0;
  int checks = 0;
  int cycles = 0;

  always #4 clock = ~clock;

  ssw_safety_switch #(.DETECT_CYCLES(DET), .BIT_CYCLES(BIT)) dut (
    .clock(clock), .reset(reset), .first_chain_input(first_chain_input),
    .second_chain_input(second_chain_input), .actuator_present(actuator_present),
    .device_ready(device_ready), .diag_receive_input(diag_receive_input),
    .chain_position(4'h5), .serial_number(16'hA5C3), .teach_remaining(8'h07),
    .actuator_name(16'h1234), .safety_out_first(safety_out_first),
    .safety_out_second(safety_out_second), .signal_diag_output(signal_diag_output),
    .input_led(input_led), .device_led(device_led),
    .feasibility_error(feasibility_error), .diag_mode(diag_mode));

  ssw_fieldbus_model #(.BIT_CYCLES(BIT)) fb (
    .clock(clock), .signal_diag_output(signal_diag_output),
    .diag_receive_input(diag_receive_input));

  task automatic complete_run();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Hard ceiling well above five chain transfers of about 1200 to 1300 cycles each
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Pins change at the falling edge, then settle for ten cycles
  task automatic set_in(input logic a, input logic b, input logic p);
    first_chain_input = a;
    second_chain_input = b;
    actuator_present = p;
    repeat (10) @(negedge clock);
  endtask

  task automatic t_truth();
    logic [1:0] pat [4] = '{2'b11, 2'b00, 2'b10, 2'b01};
    for (int i = 0; i < 4; i++) begin
      set_in(pat[i][1], pat[i][0], 1'b1);
      check("outs", {safety_out_first, safety_out_second}, pat[i]);
      check("sig", signal_diag_output, 1'b1);
    end
    set_in(1'b1, 1'b1, 1'b0);
    check("off", {safety_out_first, safety_out_second, signal_diag_output}, 3'b000);
    set_in(1'b1, 1'b1, 1'b1);
    check("back", {safety_out_first, safety_out_second, signal_diag_output}, 3'b111);
    device_ready = 1'b0;
    set_in(1'b1, 1'b1, 1'b1);
    check("unready", {safety_out_first, safety_out_second, device_led}, {2'b00, DEV_RED});
    device_ready = 1'b1;
    set_in(1'b1, 1'b1, 1'b1);
  endtask

  task automatic t_lock();
    set_in(1'b0, 1'b1, 1'b1);
    check("ueq", {safety_out_first, input_led, device_led}, {1'b0, LED_FAST_FLASH, DEV_RED_FLASH});
    set_in(1'b1, 1'b1, 1'b1);
    check("lock", {safety_out_first, safety_out_second, feasibility_error}, 3'b011);
    check("lled", {input_led, device_led}, {LED_FLASH, DEV_RED_FLASH});
    set_in(1'b1, 1'b0, 1'b1);
    check("held", safety_out_first, 1'b0);
    set_in(1'b0, 1'b0, 1'b1);
    set_in(1'b1, 1'b1, 1'b1);
    check("free", {safety_out_first, safety_out_second, feasibility_error}, 3'b110);
  endtask

  // A high line shorter than the detect count leaves chain mode off
  task automatic t_nochain();
    fb.attached = 1'b1;
    repeat (DET / 2) @(negedge clock);
    fb.attached = 1'b0;
    repeat (DET * 2) @(negedge clock);
    check("nomode", diag_mode, 1'b0);
    check("nsig", signal_diag_output, 1'b1);
  endtask

  task automatic t_chain();
    logic [15:0] w;
    logic ok;
    fb.attached = 1'b1;
    repeat (DET + 20) @(negedge clock);
    check("mode", diag_mode, 1'b1);
    check("idle", signal_diag_output, 1'b1);
    fb.xfer({4'h5, CMD_SERIAL}, w, ok);
    check("frame", ok, 1'b1);
    check("serial", w, 16'hA5C3);
    fb.xfer({4'h5, CMD_CONFIG}, w, ok);
    check("cframe", ok, 1'b1);
    check("config", w, 16'h0700);
    fb.xfer({4'h6, CMD_SERIAL}, w, ok);
    check("foreign", ok, 1'b0);
    check("quiet", w, 16'hFFFF);
    set_in(1'b0, 1'b0, 1'b1);
    check("souts", {safety_out_first, safety_out_second}, 2'b00);
    set_in(1'b1, 1'b1, 1'b1);
    fb.xfer({4'h5, CMD_STATUS}, w, ok);
    check("sframe", ok, 1'b1);
    check("status", w, 16'h009F);
    reset = 1'b1;
    repeat (2) @(negedge clock);
    check("rmode", {diag_mode, signal_diag_output}, 2'b00);
    reset = 1'b0;
    repeat (DET + 20) @(negedge clock);
    check("remode", diag_mode, 1'b1);
    fb.xfer({4'h5, CMD_NAME}, w, ok);
    check("nframe", ok, 1'b1);
    check("name", w, 16'h1234);
  endtask

  initial begin
    repeat (16) @(negedge clock);
    reset = 1'b0;
    repeat (8) @(negedge clock);
    t_truth();
    t_lock();
    t_nochain();
    t_chain();
    complete_run();
  end
endmodule // tb_ssw_safety_switch
